/* File: adc_ctrl_pkg.sv */
// Constants, register map and types of the converter control block.
// Assumes a 25 MHz bus clock and a simple strobe-based register port.
//
// Notes on behaviour
// - With interrupt enable 0, each finished conversion sets the done flag.
// - Status/control write or result read clears the done flag.
// - Reset clears the done flag.
// - With interrupt enable 1, the done flag reads as 0.
// - With interrupt enable 1, each finished conversion raises an interrupt request.
// - Result read or status/control write withdraws the pending interrupt request.
// - Reset clears interrupt enable.
// - Five-bit channel select picks the pin; analog use overrides port logic.
// - A conversion takes 14 to 15 converter clock periods.
// - Each result is an unsigned 8-bit value.
// - Sampling lasts at least 5 converter clock periods.
// - After power-up, 14 converter clock periods pass before the first conversion starts.
// - Stop state aborts a conversion; conversions resume after stop ends.
package adc_ctrl_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register map
	localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_RESULT         = 4'h1;
	localparam logic [3:0] ADDR_CLOCK_SELECT   = 4'h2;
	localparam logic [3:0] ADDR_EVT_STATUS     = 4'h3;
	localparam logic [3:0] ADDR_EVT_CLEAR      = 4'h4;
	localparam logic [3:0] ADDR_EVT_ENABLE     = 4'h5;

	// Status/control layout
	localparam int BIT_DONE    = 7;
	localparam int BIT_IRQ_EN  = 6;
	localparam int CH_LSB      = 0;
	localparam logic [4:0] CH_RESET  = 5'h1F;
	localparam logic [4:0] CH_OFF    = 5'h1F;
	localparam int NUM_CHANNELS      = 12;

	// Converter clock divider: reset divide gives 25 MHz / 25 = 1 MHz
	localparam logic [7:0] CLKSEL_RESET = 8'h18;

	// Conversion timing in converter clock periods
	localparam logic [4:0] POWERUP_PERIODS = 5'h0E;
	localparam logic [4:0] SAMPLE_PERIODS  = 5'h05;
	localparam logic [4:0] CONV_PERIODS    = 5'h0E;

	// Event bits
	localparam int EVT_DONE  = 0;
	localparam int EVT_ABORT = 1;

	typedef enum logic [1:0] {
		ST_POWERUP = 2'b00,
		ST_SAMPLE  = 2'b01,
		ST_CONVERT = 2'b11,
		ST_STOPPED = 2'b10
	} conv_state_e;

	typedef struct packed {
		logic       irq_en;
		logic [4:0] channel;
		logic [7:0] clk_div;
	} conv_cfg_s;

endpackage

/* File: adc_tick_gen.sv */
// Converter clock tick generator: one-cycle tick every (div+1) bus clocks.
// Assumes the divider value is static while conversions run.
`timescale 1ns/10ps
module adc_tick_gen (
	// Clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst_b,
	// Control
	input  wire logic       i_run,
	input  wire logic [7:0] i_div,
	// Tick
	output logic            o_tick
);

	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic       tick_q;
	logic       tick_d;

	always_comb begin
		cnt_d  = cnt_q;
		tick_d = 1'b0;
		if (!i_run) begin
			cnt_d = 8'h00;
		end else if (cnt_q >= i_div) begin
			cnt_d  = 8'h00;
			tick_d = 1'b1;
		end else begin
			cnt_d = cnt_q + 8'h01;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_q  <= 8'h00;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign o_tick = tick_q;

endmodule

/* File: adc_conversion_control.sv */
// Conversion control and status for an 8-bit successive-approximation converter.
// Assumes the analog comparator answers within one bus clock of each trial.
`timescale 1ns/10ps
module adc_conversion_control (
	// Clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_b,
	// Register port
	input  wire logic [3:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rdata,
	// Analog front end
	input  wire logic        i_cmp_high,
	output logic      [7:0]  o_dac_code,
	output logic             o_sample,
	output logic      [11:0] o_analog_sel,
	output logic             o_powered,
	// Low-power
	input  wire logic        i_stop,
	// Interrupts
	output logic             o_conv_irq,
	output logic             o_irq
);

	////////////////////////////////////////////////////////////////////////////
	// Configuration registers
	adc_ctrl_pkg::conv_cfg_s cfg_q;
	adc_ctrl_pkg::conv_cfg_s cfg_d;
	logic                    wr_sc;
	logic                    rd_res;

	assign wr_sc  = i_wr && (i_addr == adc_ctrl_pkg::ADDR_STATUS_CONTROL);
	assign rd_res = i_rd && (i_addr == adc_ctrl_pkg::ADDR_RESULT);

	always_comb begin
		cfg_d = cfg_q;
		if (wr_sc) begin
			cfg_d.irq_en  = i_wdata[adc_ctrl_pkg::BIT_IRQ_EN];
			cfg_d.channel = i_wdata[adc_ctrl_pkg::CH_LSB +: 5];
		end
		if (i_wr && (i_addr == adc_ctrl_pkg::ADDR_CLOCK_SELECT)) begin
			cfg_d.clk_div = i_wdata;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cfg_q.irq_en  <= 1'b0;
			cfg_q.channel <= adc_ctrl_pkg::CH_RESET;
			cfg_q.clk_div <= adc_ctrl_pkg::CLKSEL_RESET;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Converter clock; software keeps the divide inside the legal band
	logic tick;

	adc_tick_gen u_tick (
		.i_ref_clk (i_ref_clk),
		.i_rst_b   (i_rst_b),
		// A status write restarts the divider so the first sampling period is whole
		.i_run     (!i_stop && !wr_sc),
		.i_div     (cfg_q.clk_div),
		.o_tick    (tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// Conversion sequencer: 5 sampling plus 8 bit-trial and 1 result period = 14
	adc_ctrl_pkg::conv_state_e st_q;
	adc_ctrl_pkg::conv_state_e st_d;
	logic [4:0] per_q;
	logic [4:0] per_d;
	logic [7:0] sar_q;
	logic [7:0] sar_d;
	logic [7:0] bit_q;
	logic [7:0] bit_d;
	logic [7:0] result_q;
	logic [7:0] result_d;
	logic       done_ev;
	logic       abort_ev;
	logic       chan_valid;

	assign chan_valid = (cfg_q.channel < 5'(adc_ctrl_pkg::NUM_CHANNELS));

	always_comb begin
		st_d     = st_q;
		per_d    = per_q;
		sar_d    = sar_q;
		bit_d    = bit_q;
		result_d = result_q;
		done_ev  = 1'b0;
		abort_ev = 1'b0;
		if (i_stop) begin
			// Stop drops the partial result; nothing is written to the result
			abort_ev = (st_q == adc_ctrl_pkg::ST_SAMPLE) || (st_q == adc_ctrl_pkg::ST_CONVERT);
			st_d  = adc_ctrl_pkg::ST_STOPPED;
			per_d = 5'h00;
		end else if (wr_sc) begin
			// A new channel write restarts sampling; power-up is never cut short
			if ((st_q == adc_ctrl_pkg::ST_SAMPLE) || (st_q == adc_ctrl_pkg::ST_CONVERT)) begin
				st_d  = adc_ctrl_pkg::ST_SAMPLE;
				per_d = 5'h00;
			end
		end else if (tick) begin
			case (st_q)
				adc_ctrl_pkg::ST_STOPPED: begin
					// Re-run power-up so analog settles after stop
					st_d  = adc_ctrl_pkg::ST_POWERUP;
					per_d = 5'h00;
				end
				adc_ctrl_pkg::ST_POWERUP: begin
					per_d = per_q + 5'h01;
					if (per_q == adc_ctrl_pkg::POWERUP_PERIODS - 5'h01) begin
						st_d  = adc_ctrl_pkg::ST_SAMPLE;
						per_d = 5'h00;
					end
				end
				adc_ctrl_pkg::ST_SAMPLE: begin
					per_d = per_q + 5'h01;
					if (!chan_valid) begin
						per_d = 5'h00;
					end else if (per_q == adc_ctrl_pkg::SAMPLE_PERIODS - 5'h01) begin
						st_d  = adc_ctrl_pkg::ST_CONVERT;
						per_d = per_q + 5'h01;
						sar_d = 8'h80;
						bit_d = 8'h80;
					end
				end
				adc_ctrl_pkg::ST_CONVERT: begin
					per_d = per_q + 5'h01;
					if (bit_q != 8'h00) begin
						if (i_cmp_high) begin
							sar_d = sar_q & ~bit_q;
						end
						bit_d = bit_q >> 1;
						if (bit_q > 8'h01) begin
							sar_d = (i_cmp_high ? (sar_q & ~bit_q) : sar_q) | (bit_q >> 1);
						end
					end
					if (per_q == adc_ctrl_pkg::CONV_PERIODS - 5'h01) begin
						result_d = sar_q;
						done_ev  = 1'b1;
						st_d     = adc_ctrl_pkg::ST_SAMPLE;
						per_d    = 5'h00;
					end
				end
				default: begin
					st_d  = adc_ctrl_pkg::ST_POWERUP;
					per_d = 5'h00;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_q     <= adc_ctrl_pkg::ST_POWERUP;
			per_q    <= 5'h00;
			sar_q    <= 8'h00;
			bit_q    <= 8'h00;
			result_q <= 8'h00;
		end else begin
			st_q     <= st_d;
			per_q    <= per_d;
			sar_q    <= sar_d;
			bit_q    <= bit_d;
			result_q <= result_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Done flag, conversion interrupt, event status
	logic       done_q;
	logic       done_d;
	logic       cirq_q;
	logic       cirq_d;
	logic [1:0] evt_q;
	logic [1:0] evt_d;
	logic [1:0] evt_en_q;
	logic [1:0] evt_en_d;
	logic       irq_q;
	logic       irq_d;
	logic       clr_done;

	assign clr_done = wr_sc || rd_res;

	always_comb begin
		// Set beats clear when both land in one cycle
		done_d = (done_q && !clr_done) || (done_ev && !cfg_q.irq_en);
		cirq_d = (cirq_q && !clr_done) || (done_ev && cfg_q.irq_en);
		if (cfg_q.irq_en) begin
			done_d = 1'b0;
		end
		evt_d = evt_q;
		if (i_wr && (i_addr == adc_ctrl_pkg::ADDR_EVT_CLEAR)) begin
			evt_d = evt_q & ~i_wdata[1:0];
		end
		evt_d[adc_ctrl_pkg::EVT_DONE]  = evt_d[adc_ctrl_pkg::EVT_DONE] | done_ev;
		evt_d[adc_ctrl_pkg::EVT_ABORT] = evt_d[adc_ctrl_pkg::EVT_ABORT] | abort_ev;
		evt_en_d = evt_en_q;
		if (i_wr && (i_addr == adc_ctrl_pkg::ADDR_EVT_ENABLE)) begin
			evt_en_d = i_wdata[1:0];
		end
		irq_d = |(evt_d & evt_en_d);
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			done_q   <= 1'b0;
			cirq_q   <= 1'b0;
			evt_q    <= 2'h0;
			evt_en_q <= 2'h0;
			irq_q    <= 1'b0;
		end else begin
			done_q   <= done_d;
			cirq_q   <= cirq_d;
			evt_q    <= evt_d;
			evt_en_q <= evt_en_d;
			irq_q    <= irq_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data and analog outputs, all registered
	logic [7:0]  rdata_d;
	logic [7:0]  rdata_q;
	logic [11:0] sel_d;
	logic [11:0] sel_q;
	logic [7:0]  dac_q;
	logic        samp_q;
	logic        pwr_q;

	always_comb begin
		rdata_d = 8'h00;
		if (i_rd) begin
			case (i_addr)
				adc_ctrl_pkg::ADDR_STATUS_CONTROL: begin
					rdata_d = {done_q && !cfg_q.irq_en, cfg_q.irq_en, 1'b0, cfg_q.channel};
				end
				adc_ctrl_pkg::ADDR_RESULT:       rdata_d = result_q;
				adc_ctrl_pkg::ADDR_CLOCK_SELECT: rdata_d = cfg_q.clk_div;
				adc_ctrl_pkg::ADDR_EVT_STATUS:   rdata_d = {6'h00, evt_q};
				adc_ctrl_pkg::ADDR_EVT_ENABLE:   rdata_d = {6'h00, evt_en_q};
				default:                         rdata_d = 8'h00;
			endcase
		end
		// One-hot pin claim; claimed pin is forced analog over port logic
		sel_d = 12'h000;
		if (chan_valid) begin
			sel_d[cfg_q.channel[3:0]] = 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rdata_q <= 8'h00;
			sel_q   <= 12'h000;
			dac_q   <= 8'h00;
			samp_q  <= 1'b0;
			pwr_q   <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			sel_q   <= sel_d;
			dac_q   <= sar_d;
			samp_q  <= (st_d == adc_ctrl_pkg::ST_SAMPLE);
			pwr_q   <= (st_d != adc_ctrl_pkg::ST_STOPPED);
		end
	end

	assign o_rdata      = rdata_q;
	assign o_analog_sel = sel_q;
	assign o_dac_code   = dac_q;
	assign o_sample     = samp_q;
	assign o_powered    = pwr_q;
	assign o_conv_irq   = cirq_q;
	assign o_irq        = irq_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	done_needs_ev_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		$rose(done_q) |-> $past(done_ev) && !$past(cfg_q.irq_en))
		else $error("done flag rose without a finished conversion");
	done_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		done_ev && !cfg_q.irq_en |=> done_q)
		else $error("done flag not set at conversion end");
	done_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		clr_done && !done_ev |=> !done_q)
		else $error("done flag survived a clearing access");
	done_read_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		i_rd && i_addr == adc_ctrl_pkg::ADDR_STATUS_CONTROL && cfg_q.irq_en |=> !o_rdata[7])
		else $error("done flag read as one with interrupt enabled");
	irq_raise_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		done_ev && cfg_q.irq_en |=> o_conv_irq && result_q == $past(sar_q))
		else $error("interrupt or result missing at conversion end");
	irq_withdraw_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		clr_done && !done_ev |=> !o_conv_irq)
		else $error("interrupt not withdrawn on clearing access");
	conv_length_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		done_ev |-> per_q == adc_ctrl_pkg::CONV_PERIODS - 5'h01)
		else $error("conversion length wrong");
	sample_min_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		st_q == adc_ctrl_pkg::ST_SAMPLE && st_d == adc_ctrl_pkg::ST_CONVERT
		|-> per_q == adc_ctrl_pkg::SAMPLE_PERIODS - 5'h01)
		else $error("sampling phase too short");
	stop_abort_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		i_stop |=> st_q == adc_ctrl_pkg::ST_STOPPED && !done_ev)
		else $error("conversion not aborted in stop");
	pin_claim_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		##1 $past(chan_valid) |-> o_analog_sel == 12'(12'h001 << $past(cfg_q.channel[3:0])))
		else $error("analog pin claim wrong");

endmodule

/* File: tb.sv */
// Self-checking bench for the converter control block.
// Assumes a registered comparator model and a converter clock near 1 MHz.
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
	logic        i_ref_clk;
	logic        i_rst_b;
	logic [3:0]  i_addr;
	logic [7:0]  i_wdata;
	logic        i_wr;
	logic        i_rd;
	logic        i_cmp_high;
	logic        i_stop;
	logic [7:0]  o_rdata;
	logic [7:0]  o_dac_code;
	logic        o_sample;
	logic [11:0] o_analog_sel;
	logic        o_powered;
	logic        o_conv_irq;
	logic        o_irq;
	logic [7:0]  vin;
	logic [7:0]  rv;
	int          error_cnt;
	int          n_compared;
	int          cyc;
	int          smp;
	int          tmo;

	// Bus clocks per converter period at divide 8'h17
	localparam int TICK = 24;

	////////////////////////////////////////////////////////////////////////////
	adc_conversion_control i_dut (
		.i_ref_clk    (i_ref_clk),
		.i_rst_b      (i_rst_b),
		.i_addr       (i_addr),
		.i_wdata      (i_wdata),
		.i_wr         (i_wr),
		.i_rd         (i_rd),
		.o_rdata      (o_rdata),
		.i_cmp_high   (i_cmp_high),
		.o_dac_code   (o_dac_code),
		.o_sample     (o_sample),
		.o_analog_sel (o_analog_sel),
		.o_powered    (o_powered),
		.i_stop       (i_stop),
		.o_conv_irq   (o_conv_irq),
		.o_irq        (o_irq)
	);

	always #20 i_ref_clk = ~i_ref_clk;

	// Comparator answers one clock late; trials are a converter period apart
	always @(posedge i_ref_clk) begin
		i_cmp_high <= (o_dac_code > vin);
	end

	// Whole run needs a few thousand clocks
	always @(posedge i_ref_clk) begin
		tmo++;
		if (tmo == 10000) begin
			error_cnt++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask

	task automatic rd_val(input logic [3:0] a, output logic [7:0] v);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1;
		v = o_rdata;
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
		logic [7:0] v;
		rd_val(a, v);
		`CHK(v & m, e & m)
	endtask

	// Status reads leave the done flag alone, so polling is safe
	task automatic poll_done();
		rv = 8'h00;
		for (int k = 0; k < 500 && rv[7] !== 1'b1; k++) begin
			rd_val(adc_ctrl_pkg::ADDR_STATUS_CONTROL, rv);
		end
	endtask

	task automatic wait_irq(input int lim);
		cyc = 0;
		smp = 0;
		@(posedge i_ref_clk);
		#1;
		while (o_conv_irq !== 1'b1 && cyc < lim) begin
			cyc++;
			if (o_sample === 1'b1) begin
				smp++;
			end
			@(posedge i_ref_clk);
			#1;
		end
		if (cyc >= lim) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, cyc, lim);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		i_ref_clk = 1'b0;
		i_rst_b = 1'b0;
		i_addr = 4'h0;
		i_wdata = 8'h00;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_cmp_high = 1'b0;
		i_stop = 1'b0;
		vin = 8'hA5;
		error_cnt = 0;
		n_compared = 0;
		tmo = 0;
		repeat (3) @(posedge i_ref_clk);
		i_rst_b <= 1'b1;
		rd_chk(adc_ctrl_pkg::ADDR_STATUS_CONTROL, 8'h1F, 8'hFF);
		`CHK(o_conv_irq, 1'b0)
		rd_chk(adc_ctrl_pkg::ADDR_CLOCK_SELECT, adc_ctrl_pkg::CLKSEL_RESET, 8'hFF);
		rd_chk(4'hF, 8'h00, 8'hFF);
		// Divide by 24 keeps the converter clock near 1.04 MHz
		wr_reg(adc_ctrl_pkg::ADDR_CLOCK_SELECT, 8'h17);
		rd_chk(adc_ctrl_pkg::ADDR_CLOCK_SELECT, 8'h17, 8'hFF);
		for (int c = 0; c < 14; c++) begin
			wr_reg(adc_ctrl_pkg::ADDR_STATUS_CONTROL, 8'(c));
			repeat (2) @(posedge i_ref_clk);
			#1;
			`CHK(o_analog_sel, (c < 12) ? (12'h001 << c) : 12'h000)
		end
		// Flag mode, both clearing accesses
		wr_reg(adc_ctrl_pkg::ADDR_STATUS_CONTROL, 8'h03);
		poll_done();
		`CHK(rv[7], 1'b1)
		rd_chk(adc_ctrl_pkg::ADDR_RESULT, vin, 8'hFF);
		rd_chk(adc_ctrl_pkg::ADDR_STATUS_CONTROL, 8'h03, 8'hFF);
		poll_done();
		wr_reg(adc_ctrl_pkg::ADDR_STATUS_CONTROL, 8'h03);
		rd_chk(adc_ctrl_pkg::ADDR_STATUS_CONTROL, 8'h03, 8'hFF);
		// Event interrupt: raise, clear, mask
		wr_reg(adc_ctrl_pkg::ADDR_EVT_CLEAR, 8'h03);
		wr_reg(adc_ctrl_pkg::ADDR_EVT_ENABLE, 8'h01);
		`CHK(o_irq, 1'b0)
		poll_done();
		@(posedge i_ref_clk);
		#1;
		`CHK(o_irq, 1'b1)
		wr_reg(adc_ctrl_pkg::ADDR_EVT_CLEAR, 8'h03);
		rd_chk(adc_ctrl_pkg::ADDR_EVT_STATUS, 8'h00, 8'h03);
		`CHK(o_irq, 1'b0)
		wr_reg(adc_ctrl_pkg::ADDR_EVT_ENABLE, 8'h00);
		rd_chk(adc_ctrl_pkg::ADDR_RESULT, vin, 8'hFF);
		poll_done();
		rd_chk(adc_ctrl_pkg::ADDR_EVT_STATUS, 8'h01, 8'h01);
		`CHK(o_irq, 1'b0)
		// Interrupt mode and conversion timing
		wr_reg(adc_ctrl_pkg::ADDR_STATUS_CONTROL, 8'h43);
		wait_irq(400);
		`CHK(cyc + 1 >= int'(adc_ctrl_pkg::CONV_PERIODS) * TICK, 1'b1)
		`CHK(cyc + 1 <= (int'(adc_ctrl_pkg::CONV_PERIODS) + 1) * TICK, 1'b1)
		`CHK(smp >= int'(adc_ctrl_pkg::SAMPLE_PERIODS) * TICK, 1'b1)
		`CHK(o_conv_irq, 1'b1)
		`CHK(o_dac_code, vin)
		rd_chk(adc_ctrl_pkg::ADDR_STATUS_CONTROL, 8'h43, 8'hFF);
		rd_chk(adc_ctrl_pkg::ADDR_RESULT, vin, 8'hFF);
		`CHK(o_conv_irq, 1'b0)
		wait_irq(400);
		wr_reg(adc_ctrl_pkg::ADDR_STATUS_CONTROL, 8'h43);
		@(posedge i_ref_clk);
		#1;
		`CHK(o_conv_irq, 1'b0)
		// Stop in mid-sampling, then power-up delay before the next result
		repeat (4) @(posedge i_ref_clk);
		i_stop <= 1'b1;
		repeat (3) @(posedge i_ref_clk);
		#1;
		`CHK(o_powered, 1'b0)
		rd_chk(adc_ctrl_pkg::ADDR_EVT_STATUS, 8'h02, 8'h02);
		repeat (60) @(posedge i_ref_clk);
		#1;
		`CHK(o_conv_irq, 1'b0)
		@(posedge i_ref_clk);
		i_stop <= 1'b0;
		wait_irq(800);
		`CHK(cyc + 1 >= (int'(adc_ctrl_pkg::POWERUP_PERIODS) + int'(adc_ctrl_pkg::CONV_PERIODS)) * TICK, 1'b1)
		`CHK(o_powered, 1'b1)
		// Done flag set, then reset in mid-run
		wr_reg(adc_ctrl_pkg::ADDR_STATUS_CONTROL, 8'h03);
		poll_done();
		`CHK(rv[7], 1'b1)
		@(posedge i_ref_clk);
		i_rst_b <= 1'b0;
		repeat (3) @(posedge i_ref_clk);
		i_rst_b <= 1'b1;
		rd_chk(adc_ctrl_pkg::ADDR_STATUS_CONTROL, 8'h1F, 8'hFF);
		`CHK(o_conv_irq, 1'b0)
		rd_chk(adc_ctrl_pkg::ADDR_EVT_STATUS, 8'h00, 8'h03);
		end_sim();
	end
endmodule
